// ---- rtl/mbp_mem_port.sv ----
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Pins change in high phase, else low
// - Enhanced mode: low address carries mask 3:2
// - Byte mask is active low
// - Standard low address bits; upper 30 always
// - Address pins float while drive enable low
// - Abort sampled only during own accesses
// - Line fill flag on every 8-word burst
// - Bursts only for fills and castouts
// - Line fill flag timed like address
// - Bus mode pin picks standard or enhanced
// - Standard: fetch from word 0, no merge
// - Enhanced: critical word, wrap, other subblock
// - Enhanced: merged mask on address and size
// - Write data driven during clock low phase
// - Standard size code: word 2, half 1, byte 0
// - Enhanced: size pins carry mask 1:0
// - Lock held high through locked sequence
module mbp_mem_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mclk,
  input wire logic addr_pipeline_select,
  input wire logic bus_mode_select,
  input wire logic [3:0] core_speed_select,
  input wire logic addr_outputs_drive_en,
  input wire logic abort,
  input wire logic [31:0] data_in,
  output mbp_pkg::mbp_pins_t bus_pins,
  output logic bus_pins_oe,
  output logic [31:0] data_out,
  output logic data_oe
);

  typedef enum logic {ST_IDLE, ST_RUN} mbp_state_t;

  mbp_pkg::mbp_async_t async_s1_reg, async_s2_reg;
  logic [31:0] din_s1_reg, din_s2_reg;
  logic mclk_q_reg;
  logic mclk_rise, mclk_fall;
  mbp_state_t state_reg;
  mbp_pkg::mbp_cmd_t cmd_reg;
  logic [31:0] base_reg;
  logic enh_reg;
  logic lock_reg;
  logic [3:0] issued_reg;
  logic abeat_v_reg, dbeat_v_reg;
  logic [2:0] abeat_reg, dbeat_reg;
  logic pend_reg;
  mbp_pkg::mbp_pins_t pend_pins_reg;
  logic done_reg, abort_reg;
  logic [31:0] line_mem [0:7];
  logic setup, access, wr_ctrl, start, burst, issue, is_write;
  logic [3:0] nbeats;
  mbp_pkg::mbp_pins_t pins_new, pins_idle;

  // Word of the block touched by a beat; single accesses use their own word
  function automatic logic [2:0] word_of(input logic [2:0] beat, input logic [31:0] base,
                                         input logic enh, input logic bst);
    logic [2:0] w;
    w = base[4:2];
    if (!bst)
      word_of = w;
    else if (enh)
      word_of = {w[2] ^ beat[2], w[1:0] + beat[1:0]};
    else
      word_of = beat;
  endfunction : word_of

  // Address-timed pin values for one beat
  function automatic mbp_pkg::mbp_pins_t pins_for(input logic [2:0] beat,
                                                  input mbp_pkg::mbp_cmd_t c,
                                                  input logic [31:0] base, input logic enh,
                                                  input logic lk);
    mbp_pkg::mbp_pins_t p;
    logic bst;
    bst = (c.op == mbp_pkg::OP_FILL) || (c.op == mbp_pkg::OP_CASTOUT);
    p.addr = {base[31:5], word_of(beat, base, enh, bst), base[1:0]};
    p.write_not_read = (c.op == mbp_pkg::OP_WRITE) || (c.op == mbp_pkg::OP_CASTOUT);
    p.line_fill_flag = bst;
    p.lock = lk;
    if (bst) begin
      // Whole word on every beat of a block transfer
      p.addr[1:0] = enh ? ~mbp_pkg::BYTES_ON[3:2] : mbp_pkg::WORD_ALIGN;
      p.transfer_size_code = enh ? ~mbp_pkg::BYTES_ON[1:0] : mbp_pkg::SZ_WORD;
    end else if (enh) begin
      p.addr[1:0] = ~c.bytes_on[3:2];
      p.transfer_size_code = ~c.bytes_on[1:0];
    end else begin
      p.transfer_size_code = c.size;
    end
    pins_for = p;
  endfunction : pins_for

  // Two flops on every pin input before any logic looks at it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_s1_reg <= '0;
      async_s2_reg <= '0;
      din_s1_reg <= 32'h0;
      din_s2_reg <= 32'h0;
      mclk_q_reg <= 1'b0;
    end else begin
      async_s1_reg <= {mclk, addr_pipeline_select, bus_mode_select, core_speed_select,
                       addr_outputs_drive_en, abort};
      async_s2_reg <= async_s1_reg;
      din_s1_reg <= data_in;
      din_s2_reg <= din_s1_reg;
      mclk_q_reg <= async_s2_reg.mclk;
    end
  end

  // Memory clock edges as seen after the synchroniser
  assign mclk_rise = async_s2_reg.mclk & ~mclk_q_reg;
  assign mclk_fall = ~async_s2_reg.mclk & mclk_q_reg;

  // APB decode
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr_ctrl = access & pwrite & (paddr == mbp_pkg::OFF_CTRL);
  assign start = wr_ctrl & pwdata[mbp_pkg::CTRL_START_BIT] & (state_reg == ST_IDLE);
  assign burst = (cmd_reg.op == mbp_pkg::OP_FILL) || (cmd_reg.op == mbp_pkg::OP_CASTOUT);
  assign nbeats = burst ? mbp_pkg::LINE_BEATS : mbp_pkg::SINGLE_BEATS;
  assign issue = (state_reg == ST_RUN) && (issued_reg < nbeats);
  assign is_write = pend_pins_reg.write_not_read;
  assign pins_new = pins_for(issued_reg[2:0], cmd_reg, base_reg, enh_reg, lock_reg);
  // Between beats the address stays put; only the burst flag drops and lock follows
  assign pins_idle = '{addr: bus_pins.addr, write_not_read: bus_pins.write_not_read,
                       transfer_size_code: bus_pins.transfer_size_code,
                       line_fill_flag: 1'b0, lock: lock_reg};

  // Answer in the first access cycle; unmapped or misaligned offsets err
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (setup) begin
        if (paddr == mbp_pkg::OFF_ADDR)
          prdata <= base_reg;
        else if (paddr == mbp_pkg::OFF_CTRL)
          prdata <= {22'h0, 1'b0, lock_reg, cmd_reg.bytes_on, cmd_reg.size, cmd_reg.op};
        else if (paddr == mbp_pkg::OFF_STAT) begin
          prdata[mbp_pkg::STAT_BUSY_BIT] <= state_reg == ST_RUN;
          prdata[mbp_pkg::STAT_DONE_BIT] <= done_reg;
          prdata[mbp_pkg::STAT_ABORT_BIT] <= abort_reg;
          prdata[mbp_pkg::STAT_MODE_BIT] <= async_s2_reg.bus_mode_select;
          prdata[mbp_pkg::STAT_PIPE_BIT] <= async_s2_reg.addr_pipeline_select;
          prdata[mbp_pkg::STAT_LOCK_BIT] <= bus_pins.lock;
          prdata[mbp_pkg::STAT_SPEED_LSB +: 4] <= async_s2_reg.core_speed_select;
        end else if ((paddr & mbp_pkg::LINE_MASK) == mbp_pkg::OFF_LINE &&
                     paddr[1:0] == mbp_pkg::WORD_ALIGN)
          prdata <= line_mem[paddr[4:2]];
        else
          pslverr <= 1'b1;
      end
    end
  end

  // Command, address and lock; settings are frozen while a transfer runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_reg <= 32'h0;
      cmd_reg <= '0;
      lock_reg <= 1'b0;
      enh_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && access && pwrite) begin
      if (paddr == mbp_pkg::OFF_ADDR)
        base_reg <= pwdata;
      if (wr_ctrl) begin
        cmd_reg.op <= mbp_pkg::mbp_op_t'(pwdata[mbp_pkg::CTRL_OP_LSB +: 2]);
        cmd_reg.size <= pwdata[mbp_pkg::CTRL_SIZE_LSB +: 2];
        cmd_reg.bytes_on <= pwdata[mbp_pkg::CTRL_BM_LSB +: 4];
        cmd_reg.lock <= pwdata[mbp_pkg::CTRL_LOCK_BIT];
        lock_reg <= pwdata[mbp_pkg::CTRL_LOCK_BIT];
        enh_reg <= async_s2_reg.bus_mode_select;
      end
    end
  end

  // Transfer sequencer: one address per memory clock, data one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      issued_reg <= 4'h0;
      abeat_v_reg <= 1'b0;
      abeat_reg <= 3'h0;
      dbeat_v_reg <= 1'b0;
      dbeat_reg <= 3'h0;
      done_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_RUN;
            issued_reg <= 4'h0;
            done_reg <= 1'b0;
          end
        end
        ST_RUN: begin
          if (mclk_rise) begin
            dbeat_v_reg <= abeat_v_reg;
            dbeat_reg <= abeat_reg;
            abeat_v_reg <= issue;
            abeat_reg <= issued_reg[2:0];
            if (issue)
              issued_reg <= issued_reg + 4'h1;
            else if (!abeat_v_reg) begin
              // Last data phase ended at the falling edge just gone
              state_reg <= ST_IDLE;
              done_reg <= 1'b1;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Address-timed pins; with pipelining off the change waits for clock low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_pins <= '0;
      pend_pins_reg <= '0;
      pend_reg <= 1'b0;
    end else if (mclk_rise) begin
      pend_pins_reg <= issue ? pins_new : pins_idle;
      if (async_s2_reg.addr_pipeline_select) begin
        bus_pins <= issue ? pins_new : pins_idle;
        pend_reg <= 1'b0;
      end else begin
        pend_reg <= 1'b1;
      end
    end else if (mclk_fall && pend_reg) begin
      bus_pins <= pend_pins_reg;
      pend_reg <= 1'b0;
    end
  end

  // Drivers float whenever the system pulls the enable low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bus_pins_oe <= 1'b0;
    else
      bus_pins_oe <= async_s2_reg.addr_outputs_drive_en;
  end

  // Data phase: writes drive the low half, reads sample at the falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= 32'h0;
      data_oe <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      if (start)
        abort_reg <= 1'b0;
      if (mclk_rise)
        data_oe <= 1'b0;
      else if (mclk_fall && dbeat_v_reg && state_reg == ST_RUN) begin
        if (cmd_reg.op == mbp_pkg::OP_WRITE || cmd_reg.op == mbp_pkg::OP_CASTOUT) begin
          data_out <= line_mem[word_of(dbeat_reg, base_reg, enh_reg, burst)];
          data_oe <= 1'b1;
        end
        if (async_s2_reg.abort)
          abort_reg <= 1'b1;
      end
    end
  end

  // Line buffer: captured read beats take priority over software writes
  always_ff @(posedge pclk) begin
    if (mclk_fall && dbeat_v_reg && state_reg == ST_RUN &&
        (cmd_reg.op == mbp_pkg::OP_READ || cmd_reg.op == mbp_pkg::OP_FILL))
      line_mem[word_of(dbeat_reg, base_reg, enh_reg, burst)] <= din_s2_reg;
    else if (access && pwrite && (paddr & mbp_pkg::LINE_MASK) == mbp_pkg::OFF_LINE &&
             paddr[1:0] == mbp_pkg::WORD_ALIGN)
      line_mem[paddr[4:2]] <= pwdata;
  end

  // Unused pending copy of direction is kept for clarity of the low-phase view
  logic unused_ok;
  assign unused_ok = is_write & cmd_reg.lock;

endmodule : mbp_mem_port
`default_nettype wire

// ---- rtl/mbp_pkg.sv ----
package mbp_pkg;
  // Register byte offsets on the APB side
  localparam logic [7:0] OFF_ADDR = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_LINE = 8'h20;
  localparam logic [7:0] LINE_MASK = 8'he0;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // Control register fields
  localparam int unsigned CTRL_OP_LSB = 0;
  localparam int unsigned CTRL_SIZE_LSB = 2;
  localparam int unsigned CTRL_BM_LSB = 4;
  localparam int unsigned CTRL_LOCK_BIT = 8;
  localparam int unsigned CTRL_START_BIT = 9;

  // Status register fields
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  localparam int unsigned STAT_ABORT_BIT = 2;
  localparam int unsigned STAT_MODE_BIT = 3;
  localparam int unsigned STAT_PIPE_BIT = 4;
  localparam int unsigned STAT_LOCK_BIT = 5;
  localparam int unsigned STAT_SPEED_LSB = 8;

  // Transfer size codes in standard mode
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  // Cache block geometry
  localparam logic [3:0] LINE_BEATS = 4'h8;
  localparam logic [3:0] SINGLE_BEATS = 4'h1;
  localparam logic [3:0] BYTES_ON = 4'hf;

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_FILL = 2'h2,
    OP_CASTOUT = 2'h3
  } mbp_op_t;

  // Command as software writes it
  typedef struct packed {
    mbp_op_t op;
    logic [1:0] size;
    logic [3:0] bytes_on;
    logic lock;
  } mbp_cmd_t;

  // Address-timed pins of the memory bus
  typedef struct packed {
    logic [31:0] addr;
    logic write_not_read;
    logic [1:0] transfer_size_code;
    logic line_fill_flag;
    logic lock;
  } mbp_pins_t;

  // Inputs that come from outside the pclk domain
  typedef struct packed {
    logic mclk;
    logic addr_pipeline_select;
    logic bus_mode_select;
    logic [3:0] core_speed_select;
    logic addr_outputs_drive_en;
    logic abort;
  } mbp_async_t;
endpackage : mbp_pkg

// ---- sim/mbp_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mbp_mem_model (
  input wire logic mclk,
  input wire mbp_pkg::mbp_pins_t bus_pins,
  input wire logic data_oe,
  input wire logic [31:0] data_out,
  output logic [31:0] data_in,
  output logic [31:0] wr_addr,
  output logic [31:0] wr_data,
  output int wr_cnt
);
  logic [31:0] beat_addr;
  initial begin
    wr_cnt = 0;
    data_in = 32'h0;
  end
  // Word set at the rise holds through the fall into the next rise
  always @(posedge mclk) begin
    beat_addr <= bus_pins.addr;
    data_in <= {bus_pins.addr[31:2], 2'h0} ^ 32'hffff0000;
  end
  // Address is latched as drive starts; data only once it has settled
  always @(posedge data_oe) wr_addr = beat_addr;
  always @(negedge data_oe) begin
    wr_data = data_out;
    wr_cnt++;
  end
endmodule : mbp_mem_model
`default_nettype wire

// ---- sim/mbp_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module mbp_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mclk,
  input wire logic addr_pipeline_select,
  input wire logic bus_mode_select,
  input wire logic addr_outputs_drive_en,
  input wire mbp_pkg::mbp_pins_t bus_pins,
  input wire logic bus_pins_oe,
  input wire logic data_oe
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Flag high on two pclk cycles in a row of one burst; mclk is looked at two cycles back, past the synchroniser
  sequence s_fill_run;
    bus_pins.line_fill_flag ##1 bus_pins.line_fill_flag;
  endsequence
  a_float_off: assert property ((!addr_outputs_drive_en)[*5] |-> !bus_pins_oe)
    else $error("address pins driven while disabled");
  a_drive_on: assert property (addr_outputs_drive_en[*5] |-> bus_pins_oe)
    else $error("address pins not driven");
  a_pipe_high: assert property (addr_pipeline_select && $changed(bus_pins.addr) |-> $past(mclk, 2))
    else $error("address moved outside mclk high");
  a_pipe_low: assert property (!addr_pipeline_select && $changed(bus_pins.addr) |-> !$past(mclk, 2))
    else $error("address moved outside mclk low");
  a_wdata_low: assert property ($rose(data_oe) |-> bus_pins.write_not_read && !$past(mclk, 2))
    else $error("write data not in mclk low");
  a_wdata_hold: assert property ($rose(data_oe) |-> data_oe[*3] ##[1:4] !data_oe)
    else $error("write data drive length wrong");
  a_burst_std: assert property (bus_pins.line_fill_flag && !bus_mode_select |-> bus_pins.transfer_size_code == 2'h2 && bus_pins.addr[1:0] == 2'h0)
    else $error("standard burst size wrong");
  a_burst_enh: assert property (bus_pins.line_fill_flag && bus_mode_select |-> bus_pins.transfer_size_code == 2'h0 && bus_pins.addr[1:0] == 2'h0)
    else $error("enhanced burst mask wrong");
  a_fill_block: assert property (s_fill_run |-> bus_pins.addr[31:5] == $past(bus_pins.addr[31:5]))
    else $error("burst left its block");
  a_fill_zero: assert property ($rose(bus_pins.line_fill_flag) && !bus_mode_select |-> bus_pins.addr[4:2] == 3'h0)
    else $error("standard fill not from word 0");
endmodule : mbp_sva
bind mbp_mem_port mbp_sva u_sva (
  .pclk(pclk),
  .presetn(presetn),
  .mclk(mclk),
  .addr_pipeline_select(addr_pipeline_select),
  .bus_mode_select(bus_mode_select),
  .addr_outputs_drive_en(addr_outputs_drive_en),
  .bus_pins(bus_pins),
  .bus_pins_oe(bus_pins_oe),
  .data_oe(data_oe)
);
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, mclk, pipe, mode, den, abt, pready, pslverr, e;
  logic bus_pins_oe, data_oe;
  logic [3:0] speed;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, data_in, data_out, wr_addr, wr_data, q;
  mbp_pkg::mbp_pins_t pins;
  int err_total, checked, cyc, wr_cnt;
  logic [2:0] ord[$];
  mbp_mem_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mclk(mclk), .addr_pipeline_select(pipe), .bus_mode_select(mode),
    .core_speed_select(speed), .addr_outputs_drive_en(den), .abort(abt), .data_in(data_in),
    .bus_pins(pins), .bus_pins_oe(bus_pins_oe), .data_out(data_out), .data_oe(data_oe));
  mbp_mem_model mem (.mclk(mclk), .bus_pins(pins), .data_oe(data_oe), .data_out(data_out),
    .data_in(data_in), .wr_addr(wr_addr), .wr_data(wr_data), .wr_cnt(wr_cnt));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Memory clock runs free, offset so its edges never meet pclk edges
  initial begin
    mclk = 1'b0;
    #7;
    forever #160 mclk = ~mclk;
  end
  // Burst word order as the memory sees it
  always @(posedge mclk) if (pins.line_fill_flag) ord.push_back(pins.addr[4:2]);
  function automatic logic [31:0] mv(input logic [31:0] a);
    return {a[31:2], 2'h0} ^ 32'hffff0000;
  endfunction : mv
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    checked++;
    if (s !== x) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Start a command, then poll until done; the timeout bounds the poll
  task automatic go(input logic [31:0] c);
    apb(1'b1, mbp_pkg::OFF_CTRL, c | (32'h1 << mbp_pkg::CTRL_START_BIT));
    ord.delete();
    apb(1'b0, mbp_pkg::OFF_STAT, 32'h0);
    while (q[mbp_pkg::STAT_DONE_BIT] !== 1'b1) apb(1'b0, mbp_pkg::OFF_STAT, 32'h0);
  endtask : go
  task automatic t_status();
    repeat (4) @(posedge pclk); // Pin levels reach status only after the synchroniser
    apb(1'b0, mbp_pkg::OFF_STAT, 32'h0);
    chk("status", {20'h0, speed, 3'h0, pipe, mode, 3'h0}, q);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    den <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("oe off", 32'h0, {31'h0, bus_pins_oe});
    den <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("oe on", 32'h1, {31'h0, bus_pins_oe});
  endtask : t_status
  // Halfword write, then reads of every size code
  task automatic t_single_std();
    apb(1'b1, mbp_pkg::OFF_ADDR, 32'h1000_0006);
    apb(1'b1, mbp_pkg::OFF_LINE + 8'h04, 32'hcafe_1234);
    go(32'h005);
    chk("wr addr", 32'h1000_0006, wr_addr);
    chk("wr data", 32'hcafe_1234, wr_data);
    chk("wnr", 32'h1, {31'h0, pins.write_not_read});
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, mbp_pkg::OFF_ADDR, 32'h1000_0010 + s);
      go(32'(s) << 2);
      chk("size", 32'(s), {30'h0, pins.transfer_size_code});
      chk("low addr", 32'h1000_0010 + s, pins.addr);
    end
  endtask : t_single_std
  task automatic t_fill(input logic m, input logic [31:0] a);
    logic [2:0] w;
    mode <= m;
    apb(1'b1, mbp_pkg::OFF_ADDR, a);
    go(32'h2);
    chk("beats", 32'h8, 32'(ord.size()));
    for (int i = 0; i < 8; i++) begin
      w = m ? {a[4] ^ (i > 3), 2'(a[3:2] + i)} : 3'(i);
      chk("beat word", {29'h0, w}, {29'h0, ord[i]});
      apb(1'b0, mbp_pkg::OFF_LINE + 8'(4 * i), 32'h0);
      chk("fill data", mv({a[31:5], 5'(4 * i)}), q);
    end
  endtask : t_fill
  task automatic t_castout();
    int n;
    mode <= 1'b0;
    for (int i = 0; i < 8; i++) apb(1'b1, mbp_pkg::OFF_LINE + 8'(4 * i), 32'h600d_0000 + i);
    apb(1'b1, mbp_pkg::OFF_ADDR, 32'h4000_0000);
    n = wr_cnt;
    go(32'h3);
    chk("writes", 32'h8, 32'(wr_cnt - n));
    chk("last addr", 32'h4000_001c, wr_addr);
    chk("last data", 32'h600d_0007, wr_data);
  endtask : t_castout
  // Read with bytes 1 and 2 enabled: mask 1001 active low
  task automatic t_enh_single();
    mode <= 1'b1;
    apb(1'b1, mbp_pkg::OFF_ADDR, 32'h5000_0008);
    go(32'h060);
    chk("mask addr", 32'h5000_000a, pins.addr);
    chk("mask size", 32'h1, {30'h0, pins.transfer_size_code});
    chk("no flag", 32'h0, {31'h0, pins.line_fill_flag});
    apb(1'b0, mbp_pkg::OFF_LINE + 8'h08, 32'h0);
    chk("rd data", mv(32'h5000_0008), q);
  endtask : t_enh_single
  task automatic t_abort_lock();
    mode <= 1'b0;
    abt <= 1'b1;
    repeat (40) @(posedge pclk);
    apb(1'b0, mbp_pkg::OFF_STAT, 32'h0);
    chk("abort off bus", 32'h0, {31'h0, q[mbp_pkg::STAT_ABORT_BIT]});
    abt <= 1'b0;
    apb(1'b1, mbp_pkg::OFF_ADDR, 32'h7000_0000);
    go(32'h108);
    chk("abort idle", 32'h0, {31'h0, q[mbp_pkg::STAT_ABORT_BIT]});
    chk("lock on", 32'h1, {31'h0, pins.lock});
    abt <= 1'b1;
    go(32'h108);
    abt <= 1'b0;
    chk("abort seen", 32'h1, {31'h0, q[mbp_pkg::STAT_ABORT_BIT]});
    apb(1'b1, mbp_pkg::OFF_CTRL, 32'h0);
    repeat (24) @(posedge pclk);
    chk("lock off", 32'h0, {31'h0, pins.lock});
  endtask : t_abort_lock
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      end_of_test();
    end
  end
  // Static pins move only while idle, between commands
  initial begin
    {presetn, psel, penable, pwrite, abt, mode, paddr, pwdata} = '0;
    pipe = 1'b1;
    speed = 4'h9;
    den = 1'b1;
    err_total = 0;
    checked = 0;
    cyc = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_status();
    t_single_std();
    t_fill(1'b0, 32'h2000_0014);
    pipe <= 1'b0;
    t_fill(1'b1, 32'h3000_0014);
    t_castout();
    t_enh_single();
    t_abort_lock();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
